/* File: hw/xcvr_pkg.sv */
// shared constants for the inverting registered bus transceiver
package xcvr_pkg;
  localparam int unsigned DATA_W      = 8;      // width of each parallel port
  localparam int unsigned FIFO_DEPTH  = 16;     // capture words held in each queue memory, plus one in its read stage
  localparam int unsigned SYNC_STAGES = 2;      // flip-flops on every pin input
  localparam logic [7:0]  STORE_RST   = 8'h00;  // storage register value after reset
  localparam logic        OE_RST      = 1'b0;   // port drivers released after reset
  localparam logic        OUT_RST     = 1'b0;   // output data bits after reset
  localparam logic        VALID_RST   = 1'b0;   // storage content unknown after reset
  localparam real         CLK_PERIOD  = 4.0;    // system clock period in nanoseconds
endpackage

/* File: hw/xcvr_fifo.sv */
// first-in first-out buffer with registered read data and valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none
module xcvr_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             clk_sys,
  input  wire logic             sys_rst,
  input  wire logic             ce,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  empty,
  output logic                  full
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] DEPTH_CNT = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      count_r;
  logic             out_valid_r;
  logic [WIDTH-1:0] out_data_r;
  wire              push;
  wire              load;

  // pointer step with wrap at the configured depth
  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction

  // handshakes: memory full stalls the source, output stage refills when drained
  assign full      = (count_r == DEPTH_CNT);
  assign in_ready  = ~full;
  assign push      = ce & in_valid & ~full;
  assign load      = ce & (count_r != '0) & (~out_valid_r | out_ready);
  assign out_valid = out_valid_r;
  assign out_data  = out_data_r;
  assign empty     = (count_r == '0) & ~out_valid_r;

  // storage array, written only on an accepted push
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

  // pointers, occupancy and registered read stage
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      wr_ptr_r    <= '0;
      rd_ptr_r    <= '0;
      count_r     <= '0;
      out_valid_r <= 1'b0;
      out_data_r  <= '0;
    end else if (ce) begin
      if (push) wr_ptr_r <= ptr_inc(wr_ptr_r);
      if (load) rd_ptr_r <= ptr_inc(rd_ptr_r);
      count_r <= count_r + (AW+1)'(push) - (AW+1)'(load);
      if (load) begin
        out_valid_r <= 1'b1;
        out_data_r  <= mem_r[rd_ptr_r];
      end else if (out_ready) begin
        out_valid_r <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

/* File: hw/inv_registered_bus_xcvr.sv */
// eight-bit inverting bus transceiver with one storage register per side
`timescale 1ns/10ps
`default_nettype none
module inv_registered_bus_xcvr #(
  parameter int unsigned WIDTH = xcvr_pkg::DATA_W,
  parameter int unsigned DEPTH = xcvr_pkg::FIFO_DEPTH
) (
  input  wire logic             clk_sys,
  input  wire logic             sys_rst,
  input  wire logic             ce,
  // bus pins, split into input, output and output enable
  input  wire logic [WIDTH-1:0] a_port_bits_in,
  output logic      [WIDTH-1:0] a_port_bits_out,
  output logic                  a_port_bits_oe,
  input  wire logic [WIDTH-1:0] b_port_bits_in,
  output logic      [WIDTH-1:0] b_port_bits_out,
  output logic                  b_port_bits_oe,
  // control pins
  input  wire logic             output_enable_n,
  input  wire logic             direction,
  input  wire logic             a_capture_clock,
  input  wire logic             b_capture_clock,
  input  wire logic             a_to_b_source_select,
  input  wire logic             b_to_a_source_select,
  // storage path control and status
  input  wire logic             store_hold,
  output logic                  a_capture_ready,
  output logic                  b_capture_ready,
  output logic                  a_store_valid,
  output logic                  b_store_valid,
  output logic      [WIDTH-1:0] a_store_data,
  output logic      [WIDTH-1:0] b_store_data
);
  localparam int unsigned SYNC_N = xcvr_pkg::SYNC_STAGES;

  // synchroniser chains; only the last stage is read by logic
  logic [WIDTH-1:0]  a_sync_r [SYNC_N];
  logic [WIDTH-1:0]  b_sync_r [SYNC_N];
  logic [SYNC_N-1:0] oe_n_sync_r;
  logic [SYNC_N-1:0] dir_sync_r;
  logic [SYNC_N-1:0] sel_ab_sync_r;
  logic [SYNC_N-1:0] sel_ba_sync_r;
  logic [SYNC_N-1:0] acap_sync_r;
  logic [SYNC_N-1:0] bcap_sync_r;
  logic              acap_last_r;
  logic              bcap_last_r;

  // storage registers and output stage
  logic [WIDTH-1:0] a_store_r;
  logic [WIDTH-1:0] b_store_r;
  logic             a_valid_r;
  logic             b_valid_r;
  logic [WIDTH-1:0] a_out_r;
  logic [WIDTH-1:0] a_out_nxt;
  logic [WIDTH-1:0] b_out_r;
  logic [WIDTH-1:0] b_out_nxt;
  logic             a_oe_r;
  logic             b_oe_r;

  // synchronised views
  wire [WIDTH-1:0] a_live;
  wire [WIDTH-1:0] b_live;
  wire             oe_n_s;
  wire             dir_s;
  wire             sel_ab_s;
  wire             sel_ba_s;
  wire             acap_s;
  wire             bcap_s;

  // capture and drain handshakes
  wire             a_edge;
  wire             b_edge;
  wire             a_pop_valid;
  wire             b_pop_valid;
  wire [WIDTH-1:0] a_pop_data;
  wire [WIDTH-1:0] b_pop_data;
  wire             drain_ready;
  wire             a_wr;
  wire             b_wr;
  wire             drive_a;
  wire             drive_b;

  // pick live or stored word and invert it for the port
  function automatic logic [WIDTH-1:0] inv_mux(input logic sel,
                                               input logic [WIDTH-1:0] live,
                                               input logic [WIDTH-1:0] stored);
    inv_mux = ~(sel ? stored : live);
  endfunction

  // two-stage synchronisers on every pin
  // the enable chain resets to disabled so no port is driven before the pins settle
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < SYNC_N; i++) begin
        a_sync_r[i] <= '0;
        b_sync_r[i] <= '0;
      end
      oe_n_sync_r   <= '1;
      dir_sync_r    <= '0;
      sel_ab_sync_r <= '0;
      sel_ba_sync_r <= '0;
      acap_sync_r   <= '0;
      bcap_sync_r   <= '0;
    end else if (ce) begin
      a_sync_r[0]   <= a_port_bits_in;
      b_sync_r[0]   <= b_port_bits_in;
      for (int i = 1; i < SYNC_N; i++) begin
        a_sync_r[i] <= a_sync_r[i-1];
        b_sync_r[i] <= b_sync_r[i-1];
      end
      oe_n_sync_r   <= {oe_n_sync_r[SYNC_N-2:0], output_enable_n};
      dir_sync_r    <= {dir_sync_r[SYNC_N-2:0], direction};
      sel_ab_sync_r <= {sel_ab_sync_r[SYNC_N-2:0], a_to_b_source_select};
      sel_ba_sync_r <= {sel_ba_sync_r[SYNC_N-2:0], b_to_a_source_select};
      acap_sync_r   <= {acap_sync_r[SYNC_N-2:0], a_capture_clock};
      bcap_sync_r   <= {bcap_sync_r[SYNC_N-2:0], b_capture_clock};
    end
  end

  // last synchroniser stage of each pin
  assign a_live   = a_sync_r[SYNC_N-1];
  assign b_live   = b_sync_r[SYNC_N-1];
  assign oe_n_s   = oe_n_sync_r[SYNC_N-1];
  assign dir_s    = dir_sync_r[SYNC_N-1];
  assign sel_ab_s = sel_ab_sync_r[SYNC_N-1];
  assign sel_ba_s = sel_ba_sync_r[SYNC_N-1];
  assign acap_s   = acap_sync_r[SYNC_N-1];
  assign bcap_s   = bcap_sync_r[SYNC_N-1];

  // previous capture clock level for edge detection
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      acap_last_r <= 1'b0;
      bcap_last_r <= 1'b0;
    end else if (ce) begin
      acap_last_r <= acap_s;
      bcap_last_r <= bcap_s;
    end
  end

  // rising capture edges, independent of enable and direction
  // a capture pin that idles high out of reset reads as one rising edge
  assign a_edge = acap_s & ~acap_last_r;
  assign b_edge = bcap_s & ~bcap_last_r;

  // captured words queue per side; store_hold stalls the drain
  assign drain_ready     = ~store_hold;
  assign a_wr            = ce & a_pop_valid & drain_ready;
  assign b_wr            = ce & b_pop_valid & drain_ready;
  assign a_store_valid   = a_valid_r;
  assign b_store_valid   = b_valid_r;
  assign a_store_data    = a_store_r;
  assign b_store_data    = b_store_r;

  xcvr_fifo #(
    .WIDTH (WIDTH),
    .DEPTH (DEPTH)
  ) a_fifo (
    .clk_sys   (clk_sys),
    .sys_rst   (sys_rst),
    .ce        (ce),
    .in_valid  (a_edge),
    .in_ready  (a_capture_ready),
    .in_data   (a_live),
    .out_valid (a_pop_valid),
    .out_ready (drain_ready),
    .out_data  (a_pop_data),
    .empty     (),
    .full      ()
  );

  xcvr_fifo #(
    .WIDTH (WIDTH),
    .DEPTH (DEPTH)
  ) b_fifo (
    .clk_sys   (clk_sys),
    .sys_rst   (sys_rst),
    .ce        (ce),
    .in_valid  (b_edge),
    .in_ready  (b_capture_ready),
    .in_data   (b_live),
    .out_valid (b_pop_valid),
    .out_ready (drain_ready),
    .out_data  (b_pop_data),
    .empty     (),
    .full      ()
  );

  // storage registers: loaded from the queue, otherwise held
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      a_store_r <= WIDTH'(xcvr_pkg::STORE_RST);
      b_store_r <= WIDTH'(xcvr_pkg::STORE_RST);
      a_valid_r <= xcvr_pkg::VALID_RST;
      b_valid_r <= xcvr_pkg::VALID_RST;
    end else begin
      if (a_wr) begin
        a_store_r <= a_pop_data;
        a_valid_r <= 1'b1;
      end
      if (b_wr) begin
        b_store_r <= b_pop_data;
        b_valid_r <= 1'b1;
      end
    end
  end

  // port drive decode and inverted data selection
  assign drive_a   = ~oe_n_s & ~dir_s;
  assign drive_b   = ~oe_n_s & dir_s;
  assign a_out_nxt = inv_mux(sel_ba_s, b_live, b_store_r);
  assign b_out_nxt = inv_mux(sel_ab_s, a_live, a_store_r);

  // registered outputs: a select change only swaps data on a clock edge
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      a_out_r <= {WIDTH{xcvr_pkg::OUT_RST}};
      b_out_r <= {WIDTH{xcvr_pkg::OUT_RST}};
      a_oe_r  <= xcvr_pkg::OE_RST;
      b_oe_r  <= xcvr_pkg::OE_RST;
    end else if (ce) begin
      a_out_r <= a_out_nxt;
      b_out_r <= b_out_nxt;
      a_oe_r  <= drive_a;
      b_oe_r  <= drive_b;
    end
  end

  assign a_port_bits_out = a_out_r;
  assign a_port_bits_oe  = a_oe_r;
  assign b_port_bits_out = b_out_r;
  assign b_port_bits_oe  = b_oe_r;

  // checks on capture, isolation and drive
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  a_capture_push_a: assert property (ce && a_edge && a_capture_ready ##1 ce |=> a_pop_valid)
    else $error("a capture edge was not queued");

  b_capture_push_a: assert property (ce && b_edge && b_capture_ready ##1 ce |=> b_pop_valid)
    else $error("b capture edge was not queued");

  ungated_capture_a: assert property (ce && b_oe_r && b_edge && b_capture_ready && !b_pop_valid
    ##1 ce[*2] ##0 !store_hold |=> b_valid_r && b_store_r == $past(b_live, 3))
    else $error("capture lost while port driven");

  isolate_ports_a: assert property (ce && oe_n_s |=> !a_port_bits_oe && !b_port_bits_oe)
    else $error("port driven while outputs disabled");

  hold_store_a: assert property (!a_wr |=> $stable(a_store_r))
    else $error("a storage changed without capture");

  live_b_to_a_a: assert property (ce && drive_a && !sel_ba_s
    |=> a_port_bits_oe && a_port_bits_out == ~$past(b_live))
    else $error("a port not inverted live b");

  stored_b_to_a_a: assert property (ce && drive_a && sel_ba_s |=> a_port_bits_out == ~$past(b_store_r))
    else $error("a port not inverted b storage");

  live_a_to_b_a: assert property (ce && drive_b && !sel_ab_s
    |=> b_port_bits_oe && b_port_bits_out == ~$past(a_live))
    else $error("b port not inverted live a");

  stored_a_to_b_a: assert property (ce && drive_b && sel_ab_s |=> b_port_bits_out == ~$past(a_store_r))
    else $error("b port not inverted a storage");

  select_no_drop_a: assert property (ce && drive_a && $changed(sel_ba_s)
    |=> a_port_bits_oe && !b_port_bits_oe)
    else $error("drive dropped on select change");

  first_capture_a: assert property (!a_valid_r && !a_wr |=> !a_valid_r)
    else $error("a storage valid before capture");

  hold_b_store_a: assert property (!b_wr |=> $stable(b_store_r))
    else $error("b storage changed without capture");

  single_driver_a: assert property (!(a_port_bits_oe && b_port_bits_oe))
    else $error("both ports driven at once");

  b_select_hold_a: assert property (ce && drive_b && $changed(sel_ab_s)
    |=> b_port_bits_oe && !a_port_bits_oe)
    else $error("b drive dropped on select change");

  first_b_capture_a: assert property (!b_valid_r && !b_wr |=> !b_valid_r)
    else $error("b storage valid before capture");

  frozen_state_a: assert property (!ce |=> $stable(a_store_r) && $stable(a_port_bits_out))
    else $error("state moved while clock enable low");
endmodule
`default_nettype wire

/* File: test/bus_partner.sv */
// far-side bus model: drives each parallel bus except while the transceiver drives it
`timescale 1ns/10ps
`default_nettype none
module bus_partner (
  input  wire logic [7:0] a_port_bits_out,
  input  wire logic       a_port_bits_oe,
  input  wire logic [7:0] a_drive,
  output logic      [7:0] a_wire,
  input  wire logic [7:0] b_port_bits_out,
  input  wire logic       b_port_bits_oe,
  input  wire logic [7:0] b_drive,
  output logic      [7:0] b_wire
);
  // far side lets go of a bus while the transceiver drives it, so the wire never fights
  assign a_wire = a_port_bits_oe ? a_port_bits_out : a_drive;
  assign b_wire = b_port_bits_oe ? b_port_bits_out : b_drive;
endmodule
`default_nettype wire

/* File: test/inv_registered_bus_xcvr_tb.sv */
// self-checking bench for the inverting registered bus transceiver
`timescale 1ns/10ps
`default_nettype none
module inv_registered_bus_xcvr_tb;
  localparam int unsigned DEPTH = 16;
  logic            clk_sys, sys_rst, en, oen, dir, acap, bcap, sel_ab, sel_ba, hold;
  logic      [7:0] a_drv, b_drv;
  wire logic [7:0] a_wire, b_wire, a_out, b_out, a_sto, b_sto;
  wire logic       a_oe, b_oe, a_rdy, b_rdy, a_vld, b_vld;
  int              miscompares, n_tests, cyc;

  inv_registered_bus_xcvr #(.WIDTH(8), .DEPTH(DEPTH)) inv_registered_bus_xcvr_inst (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .ce(en),
    .a_port_bits_in(a_wire), .a_port_bits_out(a_out), .a_port_bits_oe(a_oe),
    .b_port_bits_in(b_wire), .b_port_bits_out(b_out), .b_port_bits_oe(b_oe),
    .output_enable_n(oen), .direction(dir), .a_capture_clock(acap), .b_capture_clock(bcap),
    .a_to_b_source_select(sel_ab), .b_to_a_source_select(sel_ba), .store_hold(hold),
    .a_capture_ready(a_rdy), .b_capture_ready(b_rdy), .a_store_valid(a_vld), .b_store_valid(b_vld),
    .a_store_data(a_sto), .b_store_data(b_sto));

  bus_partner bus_partner_inst (
    .a_port_bits_out(a_out), .a_port_bits_oe(a_oe), .a_drive(a_drv), .a_wire(a_wire),
    .b_port_bits_out(b_out), .b_port_bits_oe(b_oe), .b_drive(b_drv), .b_wire(b_wire));

  // free-running system clock
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  task automatic tally_and_finish;
    if (miscompares == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // hang guard, far above the few hundred cycles the sequence needs
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      miscompares++;
      tally_and_finish;
    end
  end

  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one capture strobe; data settles first, strobe high and low long enough to be seen
  task automatic cap(input logic side_b, input logic [7:0] v);
    if (side_b) b_drv <= v;
    else a_drv <= v;
    step(2);
    if (side_b) bcap <= 1'b1;
    else acap <= 1'b1;
    step(3);
    if (side_b) bcap <= 1'b0;
    else acap <= 1'b0;
    step(3);
  endtask

  // new control levels, then wait past the sync and output register latency
  task automatic ctl(input logic g_n, input logic d, input logic s_ab, input logic s_ba);
    oen <= g_n;
    dir <= d;
    sel_ab <= s_ab;
    sel_ba <= s_ba;
    step(5);
  endtask

  initial begin
    {acap, bcap, sel_ab, sel_ba, dir, hold} = '0;
    en = 1'b1;
    oen = 1'b1;
    a_drv = 8'h00;
    b_drv = 8'h00;
    sys_rst = 1'b1;
    step(4);
    sys_rst <= 1'b0;
    step(2);
    // released ports and unloaded storage out of reset
    chk("oe_pair", 8'h00, {6'h0, a_oe, b_oe});
    chk("valid_pair", 8'h00, {6'h0, a_vld, b_vld});
    // isolated capture of both buses
    cap(1'b0, 8'h5a);
    cap(1'b1, 8'hc3);
    step(8);
    chk("a_store", 8'h5a, a_sto);
    chk("b_store", 8'hc3, b_sto);
    chk("valid_pair", 8'h03, {6'h0, a_vld, b_vld});
    chk("oe_pair", 8'h00, {6'h0, a_oe, b_oe});
    // live B inverted onto A, following a change of B
    b_drv <= 8'h3c;
    ctl(1'b0, 1'b0, 1'b0, 1'b0);
    chk("a_out", 8'hc3, a_out);
    chk("oe_pair", 8'h02, {6'h0, a_oe, b_oe});
    b_drv <= 8'h81;
    step(5);
    chk("a_out", 8'h7e, a_out);
    // clock enable low freezes the driven port although B moves
    en <= 1'b0;
    b_drv <= 8'h00;
    step(5);
    chk("a_out_frozen", 8'h7e, a_out);
    en <= 1'b1;
    b_drv <= 8'h81;
    step(5);
    // switch to stored B with the B strobe steady; every cycle shows old or new data only
    sel_ba <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      step(1);
      if (a_out !== 8'h7e && a_out !== 8'h3c) chk("a_out_switch", 8'h3c, a_out);
    end
    chk("a_out", 8'h3c, a_out);
    b_drv <= 8'hff;
    step(5);
    chk("a_out", 8'h3c, a_out);
    // live A inverted onto B, then stored A
    a_drv <= 8'h96;
    ctl(1'b0, 1'b1, 1'b0, 1'b0);
    // the released A pin carries the partner's word only after the A drive ends
    step(2);
    chk("b_out", 8'h69, b_out);
    chk("oe_pair", 8'h01, {6'h0, a_oe, b_oe});
    ctl(1'b0, 1'b1, 1'b1, 1'b0);
    chk("b_out", 8'ha5, b_out);
    a_drv <= 8'h11;
    step(5);
    chk("b_out", 8'ha5, b_out);
    // capture B while the transceiver itself drives B
    cap(1'b1, 8'h00);
    step(8);
    chk("b_store", 8'ha5, b_sto);
    // isolation again: storage held
    ctl(1'b1, 1'b1, 1'b1, 1'b0);
    chk("oe_pair", 8'h00, {6'h0, a_oe, b_oe});
    chk("a_store", 8'h5a, a_sto);
    // fill the A capture queue while draining is stalled, then drain it
    hold <= 1'b1;
    for (int i = 1; i <= DEPTH + 3; i++) begin
      cap(1'b0, 8'(i));
    end
    chk("a_ready", 8'h00, {7'h0, a_rdy});
    chk("b_ready", 8'h01, {7'h0, b_rdy});
    chk("a_store", 8'h5a, a_sto);
    hold <= 1'b0;
    step(100);
    chk("a_store", 8'(DEPTH + 1), a_sto);
    chk("a_ready", 8'h01, {7'h0, a_rdy});
    tally_and_finish;
  end
endmodule
`default_nettype wire
